/* logic/sca_pkg.sv */
// Purpose: shared constants of the serial receive comma-align control block
// Assumes: one aligned 32-bit word per register on an 8-bit byte address
// Notes:   bit index 0 of a word is the first bit received on the line
package sca_pkg;
    // word framing
    localparam int unsigned BYTE_W        = 10;
    localparam int unsigned WORD_W        = 20;
    localparam logic [4:0]  BIT_LAST      = 5'h13;
    localparam logic [4:0]  BYTE0_LAST    = 5'h09;
    localparam logic [4:0]  BYTE1_START   = 5'h0A;
    // positive disparity comma, oldest bit in bit 0: 0,0,1,1,1,1,1
    localparam int unsigned COMMA_W       = 7;
    localparam logic [6:0]  COMMA_PAT     = 7'h7C;
    localparam logic [4:0]  COMMA_NEXT    = 5'h07;

    // synchroniser lanes
    localparam int unsigned SY_LINK       = 0;
    localparam int unsigned SY_REF        = 1;
    localparam int unsigned SY_LINE       = 2;
    localparam int unsigned SY_LOCAL      = 3;
    localparam int unsigned SY_AMPA       = 4;
    localparam int unsigned SY_AMPB       = 5;
    localparam int unsigned SY_N          = 6;

    // loss of signal: reference clock cycles without a data transition
    localparam int unsigned LOS_REF_CYCLES = 4;
    localparam int unsigned LOS_CH        = 2;

    // register map (byte addresses)
    localparam int unsigned AXI_AW        = 8;
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_INT_STAT  = 8'h08;
    localparam logic [7:0]  OFS_INT_MASK  = 8'h0C;
    localparam logic [7:0]  OFS_RX_WORD   = 8'h10;

    // control fields
    localparam int unsigned CTRL_W        = 6;
    localparam int unsigned CB_COMMA_EN   = 0;
    localparam int unsigned CB_LOOPBACK   = 1;
    localparam int unsigned CB_EQ_ON_N    = 2;
    localparam int unsigned CB_ALT_OUT    = 3;
    localparam int unsigned CB_REF_LOCK_N = 4;
    localparam int unsigned CB_LINK_DOWN  = 5;
    localparam logic [5:0]  CTRL_RESET    = 6'h14;

    // status fields
    localparam int unsigned ST_W          = 5;
    // interrupt fields: comma seen, loss a raised, loss b raised
    localparam int unsigned INT_W         = 3;
    localparam int unsigned IB_COMMA      = 0;
    localparam int unsigned IB_LOSS_A     = 1;
    localparam logic [2:0]  MASK_RESET    = 3'h0;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

/* logic/sca_sync_if.sv */
// Purpose: carries cleaned pin levels and their edge pulses
// Assumes: all signals are on the reference clock domain
// Notes:   rise and change are one-cycle pulses
`timescale 1ns/1ns
interface sca_sync_if;
    import sca_pkg::*;
    logic [SY_N-1:0] level;
    logic [SY_N-1:0] rise;
    logic [SY_N-1:0] change;
    modport src (output level, output rise, output change);
    modport dst (input level, input rise, input change);
endinterface

/* logic/sca_pin_sync.sv */
// Purpose: brings asynchronous pins onto the reference clock
// Assumes: each pin is steady for several reference clock cycles
// Notes:   a new level counts once the second and third stages agree
`timescale 1ns/1ns
module sca_pin_sync
    import sca_pkg::*;
(
    input  wire logic            i_ref_clk,
    input  wire logic            i_rst,
    input  wire logic [SY_N-1:0] i_pins,
    sca_sync_if.src              o_sync
);
    logic [SY_N-1:0] meta_q;
    logic [SY_N-1:0] mid_q;
    logic [SY_N-1:0] late_q;
    logic [SY_N-1:0] clean_q;
    logic [SY_N-1:0] rise_q;
    logic [SY_N-1:0] chg_q;
    logic [SY_N-1:0] upd;

    // three stages; the first one is seen by the second alone
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_q <= '0;
            mid_q  <= '0;
            late_q <= '0;
        end
        else
        begin
            meta_q <= i_pins;
            mid_q  <= meta_q;
            late_q <= mid_q;
        end
    end

    // accept only agreed levels, so a glitch in one stage is ignored
    assign upd = ~(mid_q ^ late_q) & (late_q ^ clean_q);

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            clean_q <= '0;
            rise_q  <= '0;
            chg_q   <= '0;
        end
        else
        begin
            clean_q <= (clean_q & ~upd) | (late_q & upd);
            rise_q  <= upd & late_q;
            chg_q   <= upd;
        end
    end

    assign o_sync.level  = clean_q;
    assign o_sync.rise   = rise_q;
    assign o_sync.change = chg_q;
endmodule

/* logic/sca_rx_align.sv */
// Purpose: serial receive control: source select, comma align, lock mode
// Assumes: link bit clock and reference clock are far slower than i_ref_clk
// Notes:   data is taken on each rising edge of the link bit clock while the loop does not follow the reference
//
// Summary of operation
// - A positive disparity comma in the stream raises the comma found flag.
// - With comma align enabled, a comma puts the comma in word bits 0 to 6 and sets the bit counter to 7.
// - With comma align disabled, commas change nothing and the flag is low.
// - A low reference lock request disables comma detection entirely.
// - A low reference lock request makes the loop follow the reference.
// - Loopback select high takes the local input, low the line input.
// - Equalizer enable low with loopback select low switches the equalizer into the line path.
// - Link down with loopback select low keeps the loop on reference.
// - Byte 0 is word bits 0 to 9 received first, byte 1 bits 10 to 19.
// - Two recovered byte clocks run half a period apart.
// - Each loss flag rises on low amplitude or four idle reference cycles.
`timescale 1ns/1ns
module sca_rx_align
    import sca_pkg::*;
#(
    parameter int unsigned LOS_CYCLES = LOS_REF_CYCLES
)
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    input  wire logic [AXI_AW-1:0] i_s_axi_awaddr,
    input  wire logic              i_s_axi_awvalid,
    output logic                   o_s_axi_awready,
    input  wire logic [31:0]       i_s_axi_wdata,
    input  wire logic [3:0]        i_s_axi_wstrb,
    input  wire logic              i_s_axi_wvalid,
    output logic                   o_s_axi_wready,
    output logic [1:0]             o_s_axi_bresp,
    output logic                   o_s_axi_bvalid,
    input  wire logic              i_s_axi_bready,
    input  wire logic [AXI_AW-1:0] i_s_axi_araddr,
    input  wire logic              i_s_axi_arvalid,
    output logic                   o_s_axi_arready,
    output logic [31:0]            o_s_axi_rdata,
    output logic [1:0]             o_s_axi_rresp,
    output logic                   o_s_axi_rvalid,
    input  wire logic              i_s_axi_rready,
    input  wire logic              i_link_clk,
    input  wire logic              i_host_reference_clock,
    input  wire logic              i_line_serial_in,
    input  wire logic              i_local_serial_in,
    input  wire logic              i_amp_low_a,
    input  wire logic              i_amp_low_b,
    output logic [WORD_W-1:0]      o_rx_data,
    output logic [1:0]             o_recovered_byte_clocks,
    output logic                   o_comma_found_flag,
    output logic                   o_signal_loss_flag_a,
    output logic                   o_signal_loss_flag_b,
    output logic                   o_pll_track_ref,
    output logic                   o_equalizer_active,
    output logic                   o_irq
);
    localparam int unsigned LOS_W = $clog2(LOS_CYCLES + 1);

    if (LOS_CYCLES < 1 || LOS_CYCLES > 255)
    begin : g_bad_los
        $error("LOS_CYCLES must lie in 1..255");
    end

    sca_sync_if sync ();

    logic [CTRL_W-1:0] ctrl_q;
    logic [INT_W-1:0]  mask_q;
    logic [INT_W-1:0]  int_q;
    logic [INT_W-1:0]  int_ev;
    logic              aw_full_q;
    logic              w_full_q;
    logic [7:0]        aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;
    logic              wr_fire;
    logic              rd_take;
    logic              rd_ok;
    logic [31:0]       rd_word;
    logic [7:0]        rd_addr;
    logic              wr_ok;
    logic              comma_en;
    logic              step;
    logic              bit_in;
    logic [6:0]        hist_q;
    logic [6:0]        hist_d;
    logic              comma_hit;
    logic [4:0]        bit_cnt_q;
    logic [WORD_W-1:0] word_q;
    logic [WORD_W-1:0] word_d;
    logic              word_done;
    logic              byte1_evt;
    logic [BYTE_W-1:0] held_q;
    logic [WORD_W-1:0] rx_q;
    logic              flag_q;
    logic [LOS_W-1:0]  los_cnt_q [LOS_CH];
    logic              los_q     [LOS_CH];
    logic              los_nx    [LOS_CH];
    logic [ST_W-1:0]   status;

    sca_pin_sync u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_pins    ({i_amp_low_b, i_amp_low_a, i_local_serial_in,
                     i_line_serial_in, i_host_reference_clock, i_link_clk}),
        .o_sync    (sync)
    );

    // write address and data are held apart so either may come first
    assign o_s_axi_awready = !aw_full_q && !bvalid_q;
    assign o_s_axi_wready  = !w_full_q && !bvalid_q;
    assign wr_fire         = aw_full_q && w_full_q && !bvalid_q;
    assign o_s_axi_bvalid  = bvalid_q;
    assign o_s_axi_bresp   = bresp_q;
    assign wr_ok = aw_addr_q[7:2] <= OFS_RX_WORD[7:2];

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end
        else
        begin
            if (i_s_axi_awvalid && o_s_axi_awready)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= {i_s_axi_awaddr[7:2], 2'b00};
            end
            else if (wr_fire)
                aw_full_q <= 1'b0;
            if (i_s_axi_wvalid && o_s_axi_wready)
            begin
                w_full_q <= 1'b1;
                w_data_q <= i_s_axi_wdata;
                w_strb_q <= i_s_axi_wstrb;
            end
            else if (wr_fire)
                w_full_q <= 1'b0;
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (i_s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // only byte lane 0 holds writable bits
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_q <= CTRL_RESET;
            mask_q <= MASK_RESET;
        end
        else if (wr_fire && w_strb_q[0])
        begin
            if (aw_addr_q == OFS_CTRL)
                ctrl_q <= w_data_q[CTRL_W-1:0];
            if (aw_addr_q == OFS_INT_MASK)
                mask_q <= w_data_q[INT_W-1:0];
        end
    end

    // read path; one read outstanding, data held until taken
    assign o_s_axi_arready = !rvalid_q;
    assign rd_take = i_s_axi_arvalid && !rvalid_q;
    assign rd_addr = {i_s_axi_araddr[7:2], 2'b00};
    assign status  = {o_equalizer_active, o_pll_track_ref,
                      los_q[1], los_q[0], flag_q};

    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (rd_addr)
            OFS_CTRL:     rd_word = 32'(ctrl_q);
            OFS_STATUS:   rd_word = 32'(status);
            OFS_INT_STAT: rd_word = 32'(int_q);
            OFS_INT_MASK: rd_word = 32'(mask_q);
            OFS_RX_WORD:  rd_word = 32'(rx_q);
            default:      rd_ok   = 1'b0;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end
        else if (rd_take)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_q  <= rd_word;
        end
        else if (i_s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign o_s_axi_rvalid = rvalid_q;
    assign o_s_axi_rresp  = rresp_q;
    assign o_s_axi_rdata  = rdata_q;

    // sticky events; an event in the clearing read's cycle survives
    assign int_ev = {los_nx[1] && !los_q[1], los_nx[0] && !los_q[0],
                     comma_hit};

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            int_q <= '0;
        else if (rd_take && rd_addr == OFS_INT_STAT)
            int_q <= int_ev;
        else
            int_q <= int_q | int_ev;
    end

    assign o_irq = |(int_q & mask_q);

    // loop mode: the reference also holds the oscillator while link is down and loopback is off
    assign o_pll_track_ref = !ctrl_q[CB_REF_LOCK_N]
        || (ctrl_q[CB_LINK_DOWN] && !ctrl_q[CB_LOOPBACK]);
    assign o_equalizer_active = !ctrl_q[CB_EQ_ON_N]
        && !ctrl_q[CB_LOOPBACK];
    // detection needs both the enable and a released lock request
    assign comma_en = ctrl_q[CB_COMMA_EN]
        && ctrl_q[CB_REF_LOCK_N];

    // no data is recovered while the loop follows the reference
    assign step   = sync.rise[SY_LINK] && !o_pll_track_ref;
    assign bit_in = ctrl_q[CB_LOOPBACK] ? sync.level[SY_LOCAL]
                                        : sync.level[SY_LINE];
    assign hist_d = {bit_in, hist_q[COMMA_W-1:1]};
    assign comma_hit = step && comma_en && (hist_d == COMMA_PAT);
    assign word_done = step && !comma_hit && (bit_cnt_q == BIT_LAST);
    assign byte1_evt = step && !comma_hit && (bit_cnt_q == BYTE0_LAST);

    always_comb
    begin
        word_d = word_q;
        word_d[bit_cnt_q] = bit_in;
    end

    // bit counter and word assembly; a comma restarts byte 0 around it
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bit_cnt_q <= 5'h00;
            hist_q    <= 7'h00;
            word_q    <= '0;
        end
        else if (step)
        begin
            hist_q <= hist_d;
            if (comma_hit)
            begin
                word_q    <= {word_q[WORD_W-1:COMMA_W], COMMA_PAT};
                bit_cnt_q <= COMMA_NEXT;
            end
            else
            begin
                word_q    <= word_d;
                bit_cnt_q <= (bit_cnt_q == BIT_LAST) ? 5'h00
                                                     : bit_cnt_q + 5'h01;
            end
        end
    end

    // byte clock 0 falls as a word completes, clock 1 half a word later
    assign o_recovered_byte_clocks[0] = bit_cnt_q >= BYTE1_START;
    assign o_recovered_byte_clocks[1] = bit_cnt_q < BYTE1_START;

    // alternating mode trades half a word of latency on byte 1 for staggered
    // output switching
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_q   <= '0;
            held_q <= '0;
        end
        else
        begin
            if (word_done)
            begin
                rx_q[BYTE_W-1:0] <= word_d[BYTE_W-1:0];
                // kept in every mode so a switch to alternating output
                // still presents the previous word's byte 1
                held_q <= word_d[WORD_W-1:BYTE_W];
                if (!ctrl_q[CB_ALT_OUT])
                    rx_q[WORD_W-1:BYTE_W] <= word_d[WORD_W-1:BYTE_W];
            end
            if (byte1_evt && ctrl_q[CB_ALT_OUT])
                rx_q[WORD_W-1:BYTE_W] <= held_q;
        end
    end

    assign o_rx_data = rx_q;

    // flag stands for one bit period, dropped at once when disabled
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            flag_q <= 1'b0;
        else if (comma_hit)
            flag_q <= 1'b1;
        else if (step || !comma_en)
            flag_q <= 1'b0;
    end

    assign o_comma_found_flag = flag_q;

    // per input: idle reference cycles counted since the last transition
    for (genvar c = 0; c < LOS_CH; c++)
    begin : g_los
        assign los_nx[c] = sync.level[SY_AMPA + c]
            || (los_cnt_q[c] >= LOS_W'(LOS_CYCLES));
        always_ff @(posedge i_ref_clk or posedge i_rst)
        begin
            if (i_rst)
            begin
                los_cnt_q[c] <= '0;
                los_q[c]     <= 1'b0;
            end
            else
            begin
                los_q[c] <= los_nx[c];
                if (sync.change[SY_LINE + c])
                    los_cnt_q[c] <= '0;
                else if (sync.rise[SY_REF]
                         && los_cnt_q[c] < LOS_W'(LOS_CYCLES))
                    los_cnt_q[c] <= los_cnt_q[c] + LOS_W'(1);
            end
        end
    end

    assign o_signal_loss_flag_a = los_q[0];
    assign o_signal_loss_flag_b = los_q[1];

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_alt_word;
        word_done && ctrl_q[CB_ALT_OUT];
    endsequence
    sequence s_upper_kept;
        o_rx_data[WORD_W-1:BYTE_W] == $past(o_rx_data[WORD_W-1:BYTE_W]);
    endsequence

    property p_comma_flag;
        comma_hit |=> o_comma_found_flag ##1 (o_comma_found_flag
            || $past(step) || !$past(comma_en));
    endproperty
    a_comma_flag: assert property (p_comma_flag)
        else $error("comma flag missed after comma");
    property p_realign;
        comma_hit |=> bit_cnt_q == COMMA_NEXT;
    endproperty
    a_realign: assert property (p_realign)
        else $error("bit counter not realigned by comma");
    property p_disabled_quiet;
        !ctrl_q[CB_COMMA_EN] |=> !o_comma_found_flag;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("comma flag high while align disabled");
    property p_lock_blocks;
        !ctrl_q[CB_REF_LOCK_N] |-> !comma_hit && o_pll_track_ref;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks)
        else $error("comma detected during reference lock");
    property p_no_step_locked;
        o_pll_track_ref |=> $stable(bit_cnt_q);
    endproperty
    a_no_step_locked: assert property (p_no_step_locked)
        else $error("data recovered while loop follows reference");
    property p_local_src;
        step && !comma_hit && ctrl_q[CB_LOOPBACK] && bit_cnt_q == 5'h00
            |=> word_q[0] == $past(sync.level[SY_LOCAL]);
    endproperty
    a_local_src: assert property (p_local_src)
        else $error("loopback did not take the local input");
    property p_comma_slot;
        comma_hit |=> word_q[COMMA_W-1:0] == COMMA_PAT;
    endproperty
    a_comma_slot: assert property (p_comma_slot)
        else $error("comma not placed in byte 0");
    property p_plain_word;
        word_done && !ctrl_q[CB_ALT_OUT] |=> o_rx_data == $past(word_d);
    endproperty
    a_plain_word: assert property (p_plain_word)
        else $error("parallel word differs from received bits");
    property p_clocks_apart;
        o_recovered_byte_clocks[0] != o_recovered_byte_clocks[1];
    endproperty
    a_clocks_apart: assert property (p_clocks_apart)
        else $error("byte clocks not in opposite phase");
    property p_byte_clk_fall;
        $fell(o_recovered_byte_clocks[0])
            |-> $past(word_done) || $past(comma_hit);
    endproperty
    a_byte_clk_fall: assert property (p_byte_clk_fall)
        else $error("byte clock 0 fell away from a word boundary");
    property p_alt_hold;
        s_alt_word |=> s_upper_kept;
    endproperty
    a_alt_hold: assert property (p_alt_hold)
        else $error("byte 1 moved on byte clock 0 in alternating mode");
    property p_amp_loss;
        sync.level[SY_AMPA] |=> o_signal_loss_flag_a;
    endproperty
    a_amp_loss: assert property (p_amp_loss)
        else $error("loss flag a low with low amplitude");
endmodule

/* bench/sca_tx_model.sv */
// Purpose: far transmitter driving the line and local serial inputs
// Assumes: 800 ns bit period; the link clock stands low between frames
// Notes:   the local input carries the inverse of the line data
`timescale 1ns/1ns
module sca_tx_model
    import sca_pkg::*;
(
    output logic o_link_clk,
    output logic o_line,
    output logic o_local
);
    initial
    begin
        o_link_clk = 1'b0;
        o_line     = 1'b0;
        o_local    = 1'b1;
    end
    // oldest bit first; data moves only while the clock is low
    task automatic send(input logic [WORD_W-1:0] w, input int n);
        // step off the reference clock edges so no stage samples a race
        #20;
        for (int i = 0; i < n; i++)
        begin
            o_line = w[i];
            o_local = ~w[i];
            #400 o_link_clk = 1'b1;
            #400 o_link_clk = 1'b0;
        end
        // released lines flip so a stale bit never looks valid
        o_line = ~o_line;
        o_local = ~o_local;
        // return on a reference clock edge, as the caller expects
        #80;
    endtask
endmodule

/* bench/tb.sv */
// Purpose: self-checking bench of the comma-align receive control
// Assumes: registers reached over AXI4-Lite, link bits from the model
// Notes:   the host reference clock is a slowed stand-in
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb
    import sca_pkg::*;
;
    logic i_ref_clk, i_rst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
    logic i_s_axi_arvalid, i_s_axi_rready, i_host_reference_clock;
    logic i_amp_low_a, i_amp_low_b, o_s_axi_awready, o_s_axi_wready;
    logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_irq;
    logic o_comma_found_flag, o_signal_loss_flag_a, o_signal_loss_flag_b;
    logic o_pll_track_ref, o_equalizer_active;
    logic [7:0] i_s_axi_awaddr, i_s_axi_araddr;
    logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rd;
    logic [3:0] i_s_axi_wstrb;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, o_recovered_byte_clocks, rs;
    logic [19:0] o_rx_data;
    wire i_link_clk, i_line_serial_in, i_local_serial_in;
    int err_total, num_checks;
    sca_tx_model tx (.o_link_clk(i_link_clk), .o_line(i_line_serial_in),
        .o_local(i_local_serial_in));
    sca_rx_align uut (.i_ref_clk, .i_rst, .i_s_axi_awaddr, .i_s_axi_awvalid,
        .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid,
        .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
        .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
        .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_link_clk,
        .i_host_reference_clock, .i_line_serial_in, .i_local_serial_in,
        .i_amp_low_a, .i_amp_low_b, .o_rx_data, .o_recovered_byte_clocks,
        .o_comma_found_flag, .o_signal_loss_flag_a, .o_signal_loss_flag_b,
        .o_pll_track_ref, .o_equalizer_active, .o_irq);
    always #50 i_ref_clk = ~i_ref_clk;
    // slowed host reference so four cycles span several link bits
    always #1000 i_host_reference_clock = ~i_host_reference_clock;
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // one transfer; handshakes are judged at the falling edge before
    task automatic axi(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        logic ta, tw, dn;
        dn = 1'b0;
        i_s_axi_awaddr <= a;
        i_s_axi_araddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= w;
        i_s_axi_wvalid <= w;
        i_s_axi_bready <= w;
        i_s_axi_arvalid <= !w;
        i_s_axi_rready <= !w;
        for (int k = 0; k < 50 && !dn; k++)
        begin
            @(negedge i_ref_clk);
            ta = w ? i_s_axi_awvalid & o_s_axi_awready
                   : i_s_axi_arvalid & o_s_axi_arready;
            tw = i_s_axi_wvalid & o_s_axi_wready;
            dn = w ? o_s_axi_bvalid : o_s_axi_rvalid;
            rd = o_s_axi_rdata;
            rs = w ? o_s_axi_bresp : o_s_axi_rresp;
            @(posedge i_ref_clk);
            if (ta && w) i_s_axi_awvalid <= 1'b0;
            if (ta && !w) i_s_axi_arvalid <= 1'b0;
            if (tw) i_s_axi_wvalid <= 1'b0;
        end
        i_s_axi_bready <= 1'b0;
        i_s_axi_rready <= 1'b0;
        // let an edge pass so the next call never re-drives a ready here
        @(posedge i_ref_clk);
        if (!dn)
        begin
            err_total++;
            end_sim();
        end
    endtask
    task automatic t_reset();
        `CHK(o_recovered_byte_clocks, 2'h2)
        `CHK(o_pll_track_ref, 1'b0)
        axi(1'b0, OFS_CTRL, 32'h0);
        `CHK(rd[5:0], CTRL_RESET)
        axi(1'b0, 8'h14, 32'h0);
        `CHK(rs, RESP_SLVERR)
    endtask
    task automatic t_word();
        axi(1'b1, OFS_CTRL, 32'h10);
        `CHK(o_equalizer_active, 1'b1)
        `CHK(rs, RESP_OKAY)
        tx.send(20'h5A3C6, 20);
        idle(10);
        `CHK(o_rx_data, 20'h5A3C6)
        `CHK(^o_recovered_byte_clocks, 1'b1)
        axi(1'b1, OFS_CTRL, 32'h12);
        `CHK(o_equalizer_active, 1'b0)
        tx.send(20'h5A3C6, 20);
        idle(10);
        `CHK(o_rx_data, ~20'h5A3C6)
    endtask
    task automatic t_comma();
        axi(1'b1, OFS_CTRL, 32'h11);
        axi(1'b1, OFS_INT_MASK, 32'h1);
        axi(1'b0, OFS_INT_STAT, 32'h0);
        tx.send({10'h0, COMMA_PAT, 3'h5}, 10);
        idle(10);
        `CHK(o_comma_found_flag, 1'b1)
        `CHK(o_irq, 1'b1)
        tx.send(20'h01555, 13);
        idle(10);
        `CHK(o_rx_data, {13'h1555, COMMA_PAT})
        axi(1'b0, OFS_INT_STAT, 32'h0);
        `CHK(rd[IB_COMMA], 1'b1)
        idle(2);
        `CHK(o_irq, 1'b0)
    endtask
    task automatic t_lock();
        axi(1'b1, OFS_CTRL, 32'h10);
        tx.send({10'h155, COMMA_PAT, 3'h5}, 20);
        idle(10);
        `CHK(o_comma_found_flag, 1'b0)
        `CHK(o_rx_data, {10'h155, COMMA_PAT, 3'h5})
        axi(1'b1, OFS_CTRL, 32'h01);
        `CHK(o_pll_track_ref, 1'b1)
        tx.send(20'h0, 20);
        idle(10);
        `CHK(o_comma_found_flag, 1'b0)
        `CHK(o_rx_data, {10'h155, COMMA_PAT, 3'h5})
        idle(5000);
        axi(1'b1, OFS_CTRL, 32'h30);
        `CHK(o_pll_track_ref, 1'b1)
        axi(1'b1, OFS_CTRL, 32'h32);
        `CHK(o_pll_track_ref, 1'b0)
    endtask
    task automatic t_alt();
        axi(1'b1, OFS_CTRL, 32'h18);
        tx.send(20'h3C5A1, 20);
        idle(10);
        `CHK(o_rx_data, {10'h155, 10'h1A1})
        tx.send(20'h0, 10);
        idle(10);
        `CHK(o_rx_data[19:10], 10'hF1)
        tx.send(20'h0, 10);
    endtask
    task automatic t_loss();
        axi(1'b1, OFS_CTRL, 32'h10);
        i_amp_low_a <= 1'b1;
        i_amp_low_b <= 1'b1;
        idle(10);
        `CHK({o_signal_loss_flag_a, o_signal_loss_flag_b}, 2'h3)
        i_amp_low_a <= 1'b0;
        i_amp_low_b <= 1'b0;
        tx.send(20'h55555, 20);
        `CHK({o_signal_loss_flag_a, o_signal_loss_flag_b}, 2'h0)
        idle(120);
        `CHK({o_signal_loss_flag_a, o_signal_loss_flag_b}, 2'h3)
    endtask
    initial
    begin
        {i_ref_clk, i_host_reference_clock, i_amp_low_a, i_amp_low_b} = 4'h0;
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 3'h0;
        {i_s_axi_arvalid, i_s_axi_rready, i_rst} = 3'h1;
        {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = 48'h0;
        i_s_axi_wstrb = 4'hF;
        idle(10);
        i_rst <= 1'b0;
        t_reset();
        t_word();
        t_comma();
        t_lock();
        t_alt();
        t_loss();
        end_sim();
    end
endmodule
